// ### vdsp_ctrl.sv
// Controller driving the serial line buffer port of a dual-port video memory.
// Function
// [RULE1] Each shift clock rise advances the buffer pointer; 255 wraps to 0.
// [RULE2] Read word is valid after a shift rise, held until the next.
// [RULE3] Gate low enables serial access word by word; high disables it.
// [RULE4] In read mode gate acts as output enable for the data lines.
// [RULE5] In write mode gate acts as write enable; gated words not stored.
// [RULE6] Data line direction follows the most recent transfer.
// [RULE7] Apply at least 256 shift cycles in every 4 ms.
// [RULE8] Shifting with gate high still refreshes, data lines stay released.
// [RULE9] Read transfer move happens at the transfer strobe rising edge.
// [RULE10] Real-time transfer continues the stream without lost cycles.
// [RULE11] Keep shift clock running; place strobe rise within lead limits.
// [RULE12] Refresh array and line buffer within 4 ms.
// [RULE13] Shift clock period never exceeds 50000 ns.
// [RULE14] Mask/write-enable high at row strobe fall selects read transfer.
// [RULE15] Pseudo write transfer sets input mode without moving data.
// [RULE16] After a read transfer give two shift cycles before using data.
// [RULE17] Write words are sampled at the shift rise into the current slot.
// [RULE18] Device keeps a direction bit until the next transfer.
`timescale 1ns/1ps
module vdsp_ctrl #(
    parameter int RETAIN_CYC = vdsp_pkg::RETAIN_CYC_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device strobes
    output logic shift_clock_o,
    output logic shift_port_gate_n_o,
    output logic xfer_outen_n_o,
    output logic mask_wren_n_o,
    output logic row_strobe_n_o,
    // Shift data lines
    input wire logic [3:0] shift_data_lines_i,
    output logic [3:0] shift_data_lines_o,
    output logic shift_data_lines_oe_o
);
    initial begin
        if (RETAIN_CYC < 64 || RETAIN_CYC > 2 ** vdsp_pkg::CNT_W) $error("RETAIN_CYC out of range");
    end

    localparam int CNT_W_L = vdsp_pkg::CNT_W;
    logic [7:0] ctrl_q;
    logic [3:0] wdata_q;
    logic [3:0] rdata_q;
    logic [3:0] din_s1_q;
    logic [3:0] din_s2_q;
    logic [7:0] ptr_q;
    logic out_mode_q;
    logic ack_q;
    logic xfer_busy_q;
    logic [7:0] tmr_q;
    logic [1:0] warm_q;
    logic [CNT_W_L-1:0] win_q;
    logic [8:0] shifts_q;
    logic late_q;
    logic cap_pend_q;
    logic [1:0] cap_dly_q;
    logic xdir_q;
    logic xpseudo_q;
    vdsp_pkg::vdsp_xst_t st_q;
    vdsp_pkg::vdsp_ctl_t pins;
    logic [7:0] pre_q;

    wire sel_ok = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr_ctrl = sel_ok && wb_we_i && wb_adr_i == vdsp_pkg::REG_CTRL && wb_sel_i[0];
    wire wr_wdata = sel_ok && wb_we_i && wb_adr_i == vdsp_pkg::REG_WDATA && wb_sel_i[0];
    wire start_xfer = wr_ctrl && wb_dat_i[vdsp_pkg::CTRL_XFER_BIT] && st_q == vdsp_pkg::ST_IDLE;
    wire enabled = ctrl_q[vdsp_pkg::CTRL_EN_BIT];
    wire gate_off = ctrl_q[vdsp_pkg::CTRL_GATE_BIT];
    wire shift_s;
    wire shift_rise;
    wire tmr_done = (tmr_q == 8'h00);
    // One extra count because the state register changes a cycle after this condition.
    wire shift_rise_soon = !shift_s && pre_q == 8'(vdsp_pkg::XFER_TO_SHIFT_LEAD_CYC + 1);

    // Shift clock free-runs while enabled, bounding its period.
    // [RULE11] continuous shift clock
    // [RULE13] bounded shift period
    vdsp_shift_gen #(
        .HALF(vdsp_pkg::SHIFT_HALF_CYC)
    ) u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(enabled),
        .shift_o(shift_s),
        .rise_o(shift_rise)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= vdsp_pkg::CTRL_RESET;
            wdata_q <= 4'h0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= sel_ok;
            if (wr_ctrl) ctrl_q <= wb_dat_i[7:0] & 8'hfb;
            if (wr_wdata) wdata_q <= wb_dat_i[3:0];
        end
    end

    // Transfer sequence on the row strobe and transfer strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= vdsp_pkg::ST_IDLE;
            tmr_q <= 8'h00;
            xdir_q <= 1'b0;
            xpseudo_q <= 1'b0;
            out_mode_q <= 1'b0;
            warm_q <= 2'h0;
        end else begin
            if (!tmr_done) tmr_q <= tmr_q - 8'h01;
            if (shift_rise && warm_q != 2'h0) warm_q <= warm_q - 2'h1;
            unique case (st_q)
                vdsp_pkg::ST_IDLE: begin
                    if (start_xfer) begin
                        xdir_q <= wb_dat_i[vdsp_pkg::CTRL_DIR_BIT];
                        xpseudo_q <= wb_dat_i[vdsp_pkg::CTRL_PSEUDO_BIT];
                        tmr_q <= 8'(vdsp_pkg::XFER_LOW_CYC);
                        st_q <= vdsp_pkg::ST_SETUP;
                    end
                end
                vdsp_pkg::ST_SETUP: begin
                    st_q <= vdsp_pkg::ST_STROBE;
                end
                vdsp_pkg::ST_STROBE: begin
                    // [RULE11] in real-time mode, strobe rise just before a shift rise
                    if (tmr_done && (!ctrl_q[vdsp_pkg::CTRL_RT_BIT] || shift_rise_soon)) begin
                        st_q <= vdsp_pkg::ST_RELEASE;
                    end
                end
                vdsp_pkg::ST_RELEASE: begin
                    // [RULE6] direction follows this transfer
                    // [RULE18] mirror of device direction
                    out_mode_q <= xdir_q;
                    // [RULE16] two shift cycles after read
                    warm_q <= xdir_q ? 2'(vdsp_pkg::POST_READ_SHIFTS) : 2'h0;
                    st_q <= vdsp_pkg::ST_WARM;
                end
                vdsp_pkg::ST_WARM: begin
                    if (warm_q == 2'h0) st_q <= vdsp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || shift_rise) pre_q <= 8'(vdsp_pkg::SHIFT_HALF_CYC);
        else if (!shift_s && pre_q != 8'h00) pre_q <= pre_q - 8'h01;
    end

    wire in_xfer = st_q == vdsp_pkg::ST_SETUP || st_q == vdsp_pkg::ST_STROBE;
    wire row_low = st_q == vdsp_pkg::ST_STROBE || st_q == vdsp_pkg::ST_RELEASE;
    // [RULE14] mask/write-enable picks direction
    assign pins.mask_wren_n = (in_xfer || row_low) ? xdir_q : 1'b1;
    // [RULE9] strobe rises at end of low phase
    assign pins.xfer_outen_n = !in_xfer;
    assign pins.row_strobe_n = !row_low;
    assign pins.shift_clock = shift_s;
    // [RULE15] pseudo write uses the gate high at the row fall
    // [RULE3] gate low enables access
    // [RULE8] gate high during refresh shifting
    assign pins.shift_port_gate_n = (in_xfer || row_low) ? xpseudo_q : gate_off;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_clock_o <= 1'b0;
            shift_port_gate_n_o <= 1'b1;
            xfer_outen_n_o <= 1'b1;
            mask_wren_n_o <= 1'b1;
            row_strobe_n_o <= 1'b1;
        end else begin
            shift_clock_o <= pins.shift_clock;
            shift_port_gate_n_o <= pins.shift_port_gate_n;
            xfer_outen_n_o <= pins.xfer_outen_n;
            mask_wren_n_o <= pins.mask_wren_n;
            row_strobe_n_o <= pins.row_strobe_n;
        end
    end

    // Serial data: drive in write mode, capture in read mode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            din_s1_q <= 4'h0;
            din_s2_q <= 4'h0;
            rdata_q <= 4'h0;
            ptr_q <= 8'h00;
            cap_pend_q <= 1'b0;
            cap_dly_q <= 2'h0;
            shifts_q <= 9'h000;
            win_q <= '0;
            late_q <= 1'b0;
        end else begin
            din_s1_q <= shift_data_lines_i;
            din_s2_q <= din_s1_q;
            // [RULE1] pointer mirror with wrap
            if (shift_rise) ptr_q <= ptr_q + 8'h01;
            // [RULE2] sample well after access delay
            // The word settles a cycle after the pin edge and then needs two syncs.
            if (shift_rise) cap_pend_q <= out_mode_q && !gate_off && warm_q == 2'h0;
            else if (cap_dly_q == 2'h0) cap_pend_q <= 1'b0;
            if (shift_rise) cap_dly_q <= 2'h3;
            else if (cap_dly_q != 2'h0) cap_dly_q <= cap_dly_q - 2'h1;
            // [RULE10] each shift word captured in stream in read mode, with gate low, once warm-up shifts pass
            if (cap_pend_q && cap_dly_q == 2'h0) rdata_q <= din_s2_q;
            // [RULE7] count shifts per retention window
            // [RULE12] window flags late refresh
            if (win_q == CNT_W_L'(RETAIN_CYC - 1)) begin
                win_q <= '0;
                late_q <= late_q || shifts_q < 9'(vdsp_pkg::MIN_SHIFTS);
                shifts_q <= 9'h000;
            end else begin
                win_q <= win_q + 1'b1;
                if (shift_rise && shifts_q != 9'h1ff) shifts_q <= shifts_q + 9'h001;
            end
        end
    end

    // [RULE4] drive only while out_mode_q shows input mode, which lags the device until a read transfer's release
    // [RULE5] gate high blocks storage
    // [RULE17] word held across shift rise
    assign shift_data_lines_o = wdata_q;
    assign shift_data_lines_oe_o = !out_mode_q && enabled;

    assign wb_ack_o = ack_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) wb_dat_o <= 32'h0000_0000;
        else unique case (wb_adr_i)
            vdsp_pkg::REG_CTRL: wb_dat_o <= {24'h0, ctrl_q};
            vdsp_pkg::REG_STAT: wb_dat_o <= {22'h0, late_q, out_mode_q,
                                             st_q != vdsp_pkg::ST_IDLE, ptr_q[6:0]};
            vdsp_pkg::REG_WDATA: wb_dat_o <= {28'h0, wdata_q};
            vdsp_pkg::REG_RDATA: wb_dat_o <= {28'h0, rdata_q};
            default: wb_dat_o <= 32'h0000_0000;
        endcase
    end
endmodule // vdsp_ctrl

// ### vdsp_pkg.sv
// Shared constants and types for the video line buffer port controller.
package vdsp_pkg;
    // Register byte offsets.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_WDATA = 4'h8;
    localparam logic [3:0] REG_RDATA = 4'hc;
    // Control register fields.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GATE_BIT = 1;
    localparam int CTRL_XFER_BIT = 2;
    localparam int CTRL_DIR_BIT = 3;
    localparam int CTRL_PSEUDO_BIT = 4;
    localparam int CTRL_RT_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Line buffer geometry.
    localparam int WORD_W = 4;
    localparam int DEPTH = 256;
    localparam int PTR_W = 8;
    // Timing, in ns (retention in us), at a 5 ns clock.
    localparam int CLK_NS = 5;
    localparam int SHIFT_HALF_NS = 80;
    localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int XFER_LOW_NS = 200;
    localparam int XFER_LOW_CYC = (XFER_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int XFER_TO_SHIFT_LEAD_NS = 10;
    localparam int XFER_TO_SHIFT_LEAD_CYC = (XFER_TO_SHIFT_LEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RETAIN_US = 4000;
    localparam int RETAIN_CYC_DEF = RETAIN_US * 1000 / CLK_NS;
    localparam int MIN_SHIFTS = 256;
    localparam int POST_READ_SHIFTS = 2;
    localparam int CNT_W = 24;

    typedef struct packed {
        logic shift_clock;
        logic shift_port_gate_n;
        logic xfer_outen_n;
        logic mask_wren_n;
        logic row_strobe_n;
    } vdsp_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RELEASE,
        ST_WARM
    } vdsp_xst_t;
endpackage

// ### vdsp_shift_gen.sv
// Shift clock divider with a rising-edge strobe.
`timescale 1ns/1ps
module vdsp_shift_gen #(
    parameter int HALF = vdsp_pkg::SHIFT_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    // Outputs
    output logic shift_o,
    output logic rise_o
);
    initial begin
        // The half-period counter is eight bits wide.
        if (HALF < 2 || HALF > 256) $error("HALF out of range");
    end
    logic [7:0] cnt_q;
    logic shift_q;
    wire last = (cnt_q == 8'(HALF - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            shift_q <= 1'b0;
        end else if (run_i || shift_q) begin
            cnt_q <= last ? 8'h00 : cnt_q + 8'h01;
            if (last) shift_q <= ~shift_q;
        end
    end
    assign shift_o = shift_q;
    assign rise_o = last && !shift_q && run_i;
endmodule // vdsp_shift_gen

// ### vdsp_chk.sv
// Pin-level checks on the line buffer port controller.
`timescale 1ns/1ps
module vdsp_chk (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Device pins
    input wire logic shift_clock_o,
    input wire logic shift_port_gate_n_o,
    input wire logic xfer_outen_n_o,
    input wire logic mask_wren_n_o,
    input wire logic row_strobe_n_o,
    input wire logic shift_data_lines_oe_o
);
    logic dir_q;
    logic ps_q;
    logic rd_q;
    logic rt_q;
    wire ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == vdsp_pkg::REG_CTRL;
    always_ff @(posedge clk_i) begin
        if (ctrl_wr) begin
            dir_q <= wb_dat_i[vdsp_pkg::CTRL_DIR_BIT];
            ps_q <= wb_dat_i[vdsp_pkg::CTRL_PSEUDO_BIT];
            rt_q <= wb_dat_i[vdsp_pkg::CTRL_RT_BIT];
        end
        if (!row_strobe_n_o) begin
            rd_q <= mask_wren_n_o;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_reset_idle: assert property ($fell(rst_i) |-> row_strobe_n_o && xfer_outen_n_o
        && !shift_clock_o) else $error("strobes not idle after reset");
    a_shift_high: assert property ($rose(shift_clock_o) |-> ##16 !shift_clock_o)
        else $error("shift clock high too long");
    a_xfer_first: assert property ($fell(xfer_outen_n_o) |-> row_strobe_n_o)
        else $error("transfer strobe fell after row strobe");
    a_row_dir: assert property ($fell(row_strobe_n_o)
        |-> !xfer_outen_n_o && mask_wren_n_o == dir_q)
        else $error("wrong transfer kind at row fall");
    a_pseudo_gate: assert property ($fell(row_strobe_n_o) |-> shift_port_gate_n_o == ps_q)
        else $error("gate wrong at row fall");
    a_dir_follow: assert property ($rose(row_strobe_n_o)
        |-> ##[1:8] shift_data_lines_oe_o == !rd_q)
        else $error("data direction not following transfer");
    a_shift_runs: assert property ($rose(xfer_outen_n_o) |-> ##[1:32] $rose(shift_clock_o))
        else $error("shift clock stopped around transfer");
    a_rt_lead: assert property ($rose(xfer_outen_n_o) && rt_q
        |-> ##2 $rose(shift_clock_o)) else $error("real-time strobe not leading shift edge");
    c_read: cover property ($fell(row_strobe_n_o) && mask_wren_n_o);
    c_pseudo: cover property ($fell(row_strobe_n_o) && !mask_wren_n_o && shift_port_gate_n_o);
    c_drive: cover property ($rose(shift_data_lines_oe_o));
endmodule // vdsp_chk
bind vdsp_ctrl vdsp_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .shift_clock_o(shift_clock_o), .shift_port_gate_n_o(shift_port_gate_n_o),
    .xfer_outen_n_o(xfer_outen_n_o), .mask_wren_n_o(mask_wren_n_o),
    .row_strobe_n_o(row_strobe_n_o), .shift_data_lines_oe_o(shift_data_lines_oe_o));

// ### vdsp_dev.sv
// Behavioural model of the memory's serial line buffer port.
`timescale 1ns/1ps
module vdsp_dev (
    // Strobes and data lines
    input wire logic sck_i,
    input wire logic gate_n_i,
    input wire logic xfer_n_i,
    input wire logic mask_n_i,
    input wire logic row_n_i,
    input wire logic [3:0] line_i,
    output logic [3:0] data_o,
    output logic oe_o
);
    logic [3:0] lb [256];
    logic [3:0] arr [256];
    logic [7:0] ptr = 8'h00;
    logic out_q = 1'b0;
    initial data_o = 4'h0;
    assign oe_o = out_q && !gate_n_i;
    always @(negedge row_n_i) begin
        if (!xfer_n_i) begin
            out_q = mask_n_i;
            ptr = 8'h00;
            if (!mask_n_i && !gate_n_i) begin
                for (int i = 0; i < 256; i++) arr[i] = lb[i];
            end
        end
    end
    always @(posedge xfer_n_i) begin
        if (out_q) begin
            for (int i = 0; i < 256; i++) lb[i] = arr[i];
        end
    end
    always @(posedge sck_i) begin
        if (!out_q && !gate_n_i) begin
            lb[ptr] = line_i;
        end
        data_o = lb[ptr];
        ptr = ptr + 8'h01;
    end
endmodule // vdsp_dev

// ### testbench.sv
// Self-checking bench for the line buffer port controller.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, c_d, d_d, line, rel_q = 4'h0, w;
    logic [31:0] wdat = 32'h0, dat_o, q, a;
    logic ack, sck, gate_n, xfer_n, mask_n, row_n, c_oe, d_oe;
    int fails = 0, checks = 0, rises = 0, r0, n;
    integer seed = 32'hd28a;
    localparam logic [31:0] EN = 32'h1 << vdsp_pkg::CTRL_EN_BIT;
    localparam logic [31:0] GOFF = 32'h1 << vdsp_pkg::CTRL_GATE_BIT;
    localparam logic [31:0] GO = 32'h1 << vdsp_pkg::CTRL_XFER_BIT;
    localparam logic [31:0] RD = 32'h1 << vdsp_pkg::CTRL_DIR_BIT;
    localparam logic [31:0] PS = 32'h1 << vdsp_pkg::CTRL_PSEUDO_BIT;
    localparam logic [31:0] RT = 32'h1 << vdsp_pkg::CTRL_RT_BIT;
    initial forever #2.5 clk_i = ~clk_i;
    // A released line alternates each cycle between the inverse of the last word and the word itself.
    assign line = c_oe ? c_d : d_oe ? d_d : rel_q;
    always @(posedge clk_i) rel_q <= ~line;
    always @(posedge sck) rises++;
    vdsp_ctrl #(.RETAIN_CYC(10000)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .shift_clock_o(sck), .shift_port_gate_n_o(gate_n),
        .xfer_outen_n_o(xfer_n), .mask_wren_n_o(mask_n), .row_strobe_n_o(row_n),
        .shift_data_lines_i(line), .shift_data_lines_o(c_d), .shift_data_lines_oe_o(c_oe));
    vdsp_dev i_dev (.sck_i(sck), .gate_n_i(gate_n), .xfer_n_i(xfer_n), .mask_n_i(mask_n),
        .row_n_i(row_n), .line_i(line), .data_o(d_d), .oe_o(d_oe));
    task automatic wb(input logic w_e, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_e;
        adr <= ad;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic xfer(input logic [31:0] c);
        wb(1'b1, vdsp_pkg::REG_CTRL, c | EN | GO);
        do wb(1'b0, vdsp_pkg::REG_STAT, 0); while (q[7] !== 1'b0);
    endtask
    task automatic run(input logic [31:0] g, input int k);
        wb(1'b1, vdsp_pkg::REG_CTRL, g | EN);
        repeat (k) @(posedge clk_i);
        wb(1'b1, vdsp_pkg::REG_CTRL, g);
    endtask
    task automatic end_of_test();
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_i);
        fails++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, vdsp_pkg::REG_CTRL, 0);
        `CHK(q, 32'(vdsp_pkg::CTRL_RESET))
        wb(1'b0, vdsp_pkg::REG_STAT, 0);
        `CHK(q, 32'h0)
        wb(1'b0, 4'h2, 0);
        `CHK(q, 32'h0)
        xfer(PS);
        `CHK(q[8], 1'b0)
        w = 4'($random(seed));
        wb(1'b1, vdsp_pkg::REG_WDATA, {28'h0, w});
        `CHK(c_oe, 1'b1)
        `CHK(line, w)
        // Over 256 shift rises, so every buffer slot is written.
        run(0, 8400);
        wb(1'b1, vdsp_pkg::REG_WDATA, {28'h0, ~w});
        run(GOFF, 8400);
        xfer(0);
        xfer(RD);
        `CHK(q[8], 1'b1)
        `CHK(c_oe, 1'b0)
        // Real-time read transfer with the shift clock running throughout.
        xfer(RD | RT);
        `CHK(q[8], 1'b1)
        run(0, 200);
        wb(1'b0, vdsp_pkg::REG_RDATA, 0);
        `CHK(q[3:0], w)
        `CHK(line, w)
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, vdsp_pkg::REG_STAT, 0);
            a = q;
            r0 = rises;
            n = 300 + ($unsigned($random(seed)) % 3000);
            run(0, n);
            repeat (4) @(posedge clk_i);
            wb(1'b0, vdsp_pkg::REG_STAT, 0);
            `CHK(7'(q[6:0] - a[6:0]), 7'(rises - r0))
        end
        repeat (20100) @(posedge clk_i);
        wb(1'b0, vdsp_pkg::REG_STAT, 0);
        `CHK(q[9], 1'b1)
        end_of_test();
    end
endmodule // testbench
